/* File: dv/xadle_exec_tb.sv */
// Self-checking testbench for the xor and direction-load executor
`timescale 1ns/1ns
`default_nettype none
module xadle_exec_tb;
	import xadle_pkg::*;
	typedef struct {logic [11:0] i; logic [7:0] rd; logic [7:0] acc; logic z; logic we;} xadle_row_t;
	logic clk, rst_n, clk_en, instr_valid, zero_in, file_we, zero_q, instr_illegal;
	logic [11:0] instr;
	logic [4:0] file_addr;
	logic [7:0] file_rdata, file_wdata, acc_q, pa, pb, pc, acc_e;
	int errors, compares;
	xadle_row_t rows [8] = '{
		'{12'hFB5, 8'h00, 8'hB5, 1'h0, 1'h0}, '{12'hFAF, 8'h00, 8'h1A, 1'h0, 1'h0},
		'{12'h1A3, 8'hAF, 8'h1A, 1'h0, 1'h1}, '{12'h184, 8'h1A, 8'h00, 1'h1, 1'h0},
		'{12'hF5A, 8'h00, 8'h5A, 1'h0, 1'h0}, '{12'hFFF, 8'h00, 8'hA5, 1'h0, 1'h0},
		'{12'hFA5, 8'h00, 8'h00, 1'h1, 1'h0}, '{12'hFA5, 8'h00, 8'hA5, 1'h0, 1'h0}};
	xadle_exec u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .instr_valid(instr_valid),
		.instr(instr), .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
		.file_wdata(file_wdata), .zero_in(zero_in), .zero_q(zero_q), .acc_q(acc_q),
		.port_a_direction_q(pa), .port_b_direction_q(pb), .port_c_direction_q(pc),
		.instr_illegal(instr_illegal));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(string n, logic [7:0] e, logic [7:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// Drive a word just after the edge, then settle mid-cycle
	task step(logic [11:0] i, logic [7:0] rd);
		instr = i;
		file_rdata = rd;
		#49;
	endtask : step
	task tick();
		@(posedge clk);
		#1;
	endtask : tick
	task complete_run();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		errors = 0;
		compares = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		instr_valid = 1'b1;
		zero_in = 1'b0;
		instr = 12'hFFF;
		file_rdata = 8'h00;
		repeat (6) @(posedge clk);
		#1;
		rst_n = 1'b1;
		chk("acc rst", XADLE_ACC_RST, acc_q);
		chk("dir rst", XADLE_DIR_RST, pa);
		acc_e = XADLE_ACC_RST;
		for (int k = 0; k < 8; k++) begin
			step(rows[k].i, rows[k].rd);
			chk("we", {7'h00, rows[k].we}, {7'h00, file_we});
			chk("addr", {3'h0, rows[k].i[4:0]}, {3'h0, file_addr});
			if (rows[k].i[11:6] === XADLE_XF_PAT) chk("wdata", acc_e ^ rows[k].rd, file_wdata);
			tick();
			chk("acc", rows[k].acc, acc_q);
			chk("zero", {7'h00, rows[k].z}, {7'h00, zero_q});
			acc_e = rows[k].acc;
		end
		$display("table test done");
		zero_in = 1'b1;
		for (int k = 5; k < 8; k++) begin
			step(12'(k), 8'h00);
			chk("illegal", 8'h00, {7'h00, instr_illegal});
			tick();
			chk("dir", 8'hA5, (k == 5) ? pa : (k == 6) ? pb : pc);
			chk("flag", 8'h01, {7'h00, zero_q});
		end
		step(12'hFFF, 8'h00);
		tick();
		step(12'h004, 8'h00);
		chk("illegal", 8'h01, {7'h00, instr_illegal});
		tick();
		chk("dir kept", 8'hA5, pa);
		chk("acc kept", 8'h5A, acc_q);
		$display("direction test done");
		instr_valid = 1'h0;
		step(12'h1A0, 8'h3C);
		chk("idle we", 8'h00, {7'h00, file_we});
		tick();
		step(12'h180, 8'h3C);
		tick();
		chk("idle acc", 8'h5A, acc_q);
		chk("idle zero", 8'h01, {7'h00, zero_q});
		instr_valid = 1'h1;
		$display("idle test done");
		clk_en = 1'b0;
		step(12'h1A0, 8'h3C);
		chk("we off", 8'h00, {7'h00, file_we});
		tick();
		chk("acc frozen", 8'h5A, acc_q);
		chk("zero frozen", 8'h01, {7'h00, zero_q});
		clk_en = 1'b1;
		rst_n = 1'b0;
		tick();
		rst_n = 1'b1;
		chk("acc rerst", XADLE_ACC_RST, acc_q);
		chk("dir rerst", XADLE_DIR_RST, pc);
		$display("hold and reset test done");
		complete_run();
	end
endmodule : xadle_exec_tb
`default_nettype wire

/* File: pkg/xadle_pkg.sv */
// Package: encodings, field positions and reset values for the xor and direction-load executor
package xadle_pkg;
	localparam int XADLE_IW = 12;
	localparam int XADLE_DW = 8;
	// Direction-load: nine leading zeros, then a 3-bit operand
	localparam logic [8:0] XADLE_DIR_PAT = 9'h000;
	localparam int XADLE_DIR_OP_HI = 2;
	localparam logic [2:0] XADLE_DIR_FIRST = 3'h5;
	localparam logic [2:0] XADLE_DIR_LAST = 3'h7;
	localparam logic [2:0] XADLE_DIR_A = 3'h5;
	localparam logic [2:0] XADLE_DIR_B = 3'h6;
	localparam logic [2:0] XADLE_DIR_C = 3'h7;
	// Xor-literal: top four bits ones, literal in low eight
	localparam logic [3:0] XADLE_XL_PAT = 4'hF;
	localparam int XADLE_XL_HI = 11;
	localparam int XADLE_XL_LO = 8;
	// Xor-file: 0001 10df ffff
	localparam logic [5:0] XADLE_XF_PAT = 6'h06;
	localparam int XADLE_XF_HI = 11;
	localparam int XADLE_XF_LO = 6;
	localparam int XADLE_XF_DBIT = 5;
	localparam int XADLE_XF_AHI = 4;
	localparam int XADLE_AW = 5;
	// Reset values
	localparam logic [7:0] XADLE_ACC_RST = 8'h00;
	localparam logic [7:0] XADLE_DIR_RST = 8'hFF;
	typedef enum logic [1:0] {XADLE_OP_NONE, XADLE_OP_DIR, XADLE_OP_XL, XADLE_OP_XF} xadle_op_t;
endpackage : xadle_pkg

/* File: verilog/xadle_exec.sv */
// Decode and execute of direction-load, xor-literal and xor-file instructions
// How it works
// - Direction-load copies accumulator into selected direction register; flags untouched.
// - Direction-load is nine zeros plus 3-bit operand; only 5, 6, 7 valid.
// - Xor-literal (top nibble ones) puts accumulator xor literal into accumulator.
// - Xor-file xors accumulator with the addressed file register.
// - Xor-file destination bit 0 writes accumulator, 1 writes file register.
`timescale 1ns/1ns
`default_nettype none
module xadle_exec (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Instruction issue
	input wire logic instr_valid,
	input wire logic [11:0] instr,
	// File register bus
	output logic [4:0] file_addr,
	input wire logic [7:0] file_rdata,
	output logic file_we,
	output logic [7:0] file_wdata,
	// Zero flag
	input wire logic zero_in,
	output logic zero_q,
	// Accumulator and direction registers
	output logic [7:0] acc_q,
	output logic [7:0] port_a_direction_q,
	output logic [7:0] port_b_direction_q,
	output logic [7:0] port_c_direction_q,
	// Status
	output logic instr_illegal
);
	import xadle_pkg::*;

	xadle_op_t op;
	logic [7:0] result;
	logic [7:0] acc_d;
	logic zero_d;
	logic dir_bad;

	function automatic xadle_op_t decode(input logic [11:0] w);
		if (w[XADLE_IW-1:XADLE_DIR_OP_HI+1] == XADLE_DIR_PAT) begin
			return XADLE_OP_DIR;
		end else if (w[XADLE_XL_HI:XADLE_XL_LO] == XADLE_XL_PAT) begin
			return XADLE_OP_XL;
		end else if (w[XADLE_XF_HI:XADLE_XF_LO] == XADLE_XF_PAT) begin
			return XADLE_OP_XF;
		end
		return XADLE_OP_NONE;
	endfunction : decode

	assign op = instr_valid ? decode(instr) : XADLE_OP_NONE;
	assign dir_bad = (op == XADLE_OP_DIR) &&
		((instr[XADLE_DIR_OP_HI:0] < XADLE_DIR_FIRST) || (instr[XADLE_DIR_OP_HI:0] > XADLE_DIR_LAST));
	assign instr_illegal = dir_bad;
	assign file_addr = instr[XADLE_XF_AHI:0];

	always_comb begin
		result = acc_q;
		acc_d = acc_q;
		zero_d = zero_in;
		case (op)
			XADLE_OP_XL: begin
				result = acc_q ^ instr[XADLE_DW-1:0];
				acc_d = result;
				zero_d = (result == 8'h00);
			end
			XADLE_OP_XF: begin
				result = acc_q ^ file_rdata;
				if (!instr[XADLE_XF_DBIT]) begin
					acc_d = result;
				end
				zero_d = (result == 8'h00);
			end
			default: begin
				result = acc_q;
			end
		endcase
	end

	assign file_we = clk_en && (op == XADLE_OP_XF) && instr[XADLE_XF_DBIT];
	assign file_wdata = result;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			acc_q <= XADLE_ACC_RST;
			zero_q <= 1'h0;
		end else if (clk_en) begin
			acc_q <= acc_d;
			zero_q <= zero_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			port_a_direction_q <= XADLE_DIR_RST;
			port_b_direction_q <= XADLE_DIR_RST;
			port_c_direction_q <= XADLE_DIR_RST;
		end else if (clk_en && op == XADLE_OP_DIR) begin
			case (instr[XADLE_DIR_OP_HI:0])
				XADLE_DIR_A: port_a_direction_q <= acc_q;
				XADLE_DIR_B: port_b_direction_q <= acc_q;
				XADLE_DIR_C: port_c_direction_q <= acc_q;
				default: begin
				end
			endcase
		end
	end

	property p_dir_a;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && op == XADLE_OP_DIR && instr[XADLE_DIR_OP_HI:0] == XADLE_DIR_A) |=>
			port_a_direction_q == $past(acc_q);
	endproperty
	a_dir_a: assert property (p_dir_a) else $error("dir A not loaded");
	property p_dir_b;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && op == XADLE_OP_DIR && instr[XADLE_DIR_OP_HI:0] == XADLE_DIR_B) |=>
			port_b_direction_q == $past(acc_q) && $stable(port_a_direction_q);
	endproperty
	a_dir_b: assert property (p_dir_b) else $error("dir B not loaded");
	property p_dir_c;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && op == XADLE_OP_DIR && instr[XADLE_DIR_OP_HI:0] == XADLE_DIR_C) |=>
			port_c_direction_q == $past(acc_q) && $stable(port_b_direction_q);
	endproperty
	a_dir_c: assert property (p_dir_c) else $error("dir C not loaded");
	property p_dir_flag;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && op == XADLE_OP_DIR) |=> zero_q == $past(zero_in) && acc_q == $past(acc_q);
	endproperty
	a_dir_flag: assert property (p_dir_flag) else $error("dir load changed state");
	property p_dir_bad;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && dir_bad) |=> $stable(port_a_direction_q) && $stable(port_b_direction_q)
			&& $stable(port_c_direction_q);
	endproperty
	a_dir_bad: assert property (p_dir_bad) else $error("invalid operand wrote");
	property p_dir_low;
		@(posedge clk) disable iff (!rst_n)
		(instr_valid && instr[XADLE_IW-1:XADLE_DIR_OP_HI+1] == XADLE_DIR_PAT) |->
			instr_illegal == (instr[XADLE_DIR_OP_HI:0] < XADLE_DIR_FIRST);
	endproperty
	a_dir_low: assert property (p_dir_low) else $error("operand flag wrong");
	property p_xl;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && op == XADLE_OP_XL) |=> acc_q == ($past(acc_q) ^ $past(instr[7:0]));
	endproperty
	a_xl: assert property (p_xl) else $error("literal xor wrong");
	property p_xl_nowe;
		@(posedge clk) disable iff (!rst_n)
		(instr_valid && instr[XADLE_XL_HI:XADLE_XL_LO] == XADLE_XL_PAT) |-> !file_we;
	endproperty
	a_xl_nowe: assert property (p_xl_nowe) else $error("literal xor wrote file");
	property p_xf_data;
		@(posedge clk) disable iff (!rst_n)
		(op == XADLE_OP_XF) |-> file_wdata == (acc_q ^ file_rdata);
	endproperty
	a_xf_data: assert property (p_xf_data) else $error("file xor wrong");
	property p_xf_w;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && op == XADLE_OP_XF && !instr[XADLE_XF_DBIT]) |=> acc_q == $past(file_wdata);
	endproperty
	a_xf_w: assert property (p_xf_w) else $error("acc dest not written");
	property p_xf_f;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && op == XADLE_OP_XF && instr[XADLE_XF_DBIT]) |-> file_we ##1 $stable(acc_q);
	endproperty
	a_xf_f: assert property (p_xf_f) else $error("file dest wrong");
	property p_we_src;
		@(posedge clk) disable iff (!rst_n)
		file_we |-> clk_en && instr_valid && instr[XADLE_XF_DBIT]
			&& instr[XADLE_XF_HI:XADLE_XF_LO] == XADLE_XF_PAT;
	endproperty
	a_we_src: assert property (p_we_src) else $error("stray file write");
	property p_zero;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && (op == XADLE_OP_XL || op == XADLE_OP_XF)) |=> zero_q == ($past(result) == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_idle;
		@(posedge clk) disable iff (!rst_n)
		(clk_en && !instr_valid) |=> $stable(acc_q) && zero_q == $past(zero_in);
	endproperty
	a_idle: assert property (p_idle) else $error("idle cycle changed state");
	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		!clk_en |=> $stable(acc_q) && $stable(zero_q) && $stable(port_a_direction_q)
			&& $stable(port_b_direction_q) && $stable(port_c_direction_q);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved while disabled");

	c_xl_zero: cover property (@(posedge clk) clk_en && op == XADLE_OP_XL && result == 8'h00);
	c_xf_file: cover property (@(posedge clk) file_we);
	c_xf_acc: cover property (@(posedge clk) clk_en && op == XADLE_OP_XF && !instr[XADLE_XF_DBIT]);
	c_dir_c: cover property (@(posedge clk) clk_en && op == XADLE_OP_DIR
		&& instr[XADLE_DIR_OP_HI:0] == XADLE_DIR_C);
	c_dir_bad: cover property (@(posedge clk) clk_en && dir_bad);
endmodule : xadle_exec
`default_nettype wire
